// ---- jtc_pins_if.sv ----
// Purpose: Synchronised tester pins handed from the sampler to the controller
// Assumes: One core clock
// Notes: Edge flags are one-cycle pulses
`timescale 1ns/1ps
interface jtc_pins_if #(parameter int NPINS = 8);
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic trst_n;
  logic [NPINS-1:0] pad_in;
  modport src(output tck_rise, tck_fall, tms, tdi, trst_n, pad_in);
  modport dst(input tck_rise, tck_fall, tms, tdi, trst_n, pad_in);
endinterface

// ---- jtc_pkg.sv ----
// Purpose: Shared constants and types of the test access port
// Assumes: 4-bit instruction, 32-bit identification word
// Notes: Identification field values are module parameters
package jtc_pkg;
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] OP_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] OP_IDCODE = 4'h2;
  localparam logic [IR_W-1:0] OP_HIGHZ = 4'h4;
  localparam logic [IR_W-1:0] OP_BYPASS = 4'hF;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } jtc_state_t;

  typedef enum logic [1:0] {DR_BYPASS, DR_IDENT, DR_BOUNDARY} jtc_dr_sel_t;
endpackage

// ---- jtc_sync.sv ----
// Purpose: Two-stage sampling of tester and pad inputs, test clock edge finding
// Assumes: Test clock much slower than the core clock
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module jtc_sync #(
  parameter int NPINS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic [NPINS-1:0] pad_in,
  // Synchronised side
  jtc_pins_if.src io
);
  typedef struct packed {
    logic [NPINS+3:0] s1;
    logic [NPINS+3:0] s2;
    logic tck_d;
  } jtc_sync_t;

  jtc_sync_t st_ff;
  jtc_sync_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = {pad_in, trst_n, tdi, tms, tck};
    nxt_st.s2 = st_ff.s1;
    nxt_st.tck_d = st_ff.s2[0];
  end

  // Test reset reads as asserted during core reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign io.tck_rise = st_ff.s2[0] & ~st_ff.tck_d;
  assign io.tck_fall = ~st_ff.s2[0] & st_ff.tck_d;
  assign io.tms = st_ff.s2[1];
  assign io.tdi = st_ff.s2[2];
  assign io.trst_n = st_ff.s2[3];
  assign io.pad_in = st_ff.s2[NPINS+3:4];
endmodule

// ---- jtc_tap.sv ----
// Purpose: Boundary-scan test access port controller with its registers
// Assumes: Test clock, mode, data and reset pins are sampled on the core clock
// Notes: Pin edges are seen three core cycles late; test clock must stay slow
`timescale 1ns/1ps
module jtc_tap
  import jtc_pkg::*;
#(
  parameter int NPINS = 8,
  parameter logic [3:0] ID_VERSION = 4'h1,   // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h1234, // Arbitrary value
  parameter logic [10:0] ID_MFR = 11'h055    // Arbitrary value
) (
  // Core clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Tester pins
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TRST_N,
  output logic TDO,
  output logic TDO_OE,
  // Functional side of the device
  input wire logic [NPINS-1:0] CORE_OUT,
  input wire logic [NPINS-1:0] CORE_OE,
  output logic [NPINS-1:0] CORE_IN,
  // Device pads
  input wire logic [NPINS-1:0] PAD_IN,
  output logic [NPINS-1:0] PAD_OUT,
  output logic [NPINS-1:0] PAD_OE
);
  localparam int BSR_W = 2 * NPINS;
  localparam logic [ID_W-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

  typedef struct packed {
    jtc_state_t tap;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic bp;
    logic [ID_W-1:0] id_sh;
    logic [BSR_W-1:0] bsr_sh;
    logic [BSR_W-1:0] bsr_upd;
    logic tdo;
    logic tdo_oe;
    logic [NPINS-1:0] pad_out;
    logic [NPINS-1:0] pad_oe;
    logic [NPINS-1:0] core_in;
  } jtc_tap_st_t;

  jtc_tap_st_t st_ff;
  jtc_tap_st_t nxt_st;
  jtc_dr_sel_t sel;
  logic extest;
  logic highz;

  jtc_pins_if #(.NPINS(NPINS)) pins ();

  jtc_sync #(.NPINS(NPINS)) u_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .tck(TCK),
    .tms(TMS),
    .tdi(TDI),
    .trst_n(TRST_N),
    .pad_in(PAD_IN),
    .io(pins.src)
  );

  function automatic jtc_state_t tap_next(input jtc_state_t s, input logic m);
    jtc_state_t r;
    r = s;
    case (s)
      TEST_LOGIC_RESET: r = m ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE: r = m ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR: r = m ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: r = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: r = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: r = m ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: r = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: r = m ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: r = m ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR: r = m ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: r = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: r = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: r = m ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: r = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: r = m ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: r = m ? SELECT_DR : RUN_TEST_IDLE;
      default: r = TEST_LOGIC_RESET;
    endcase
    return r;
  endfunction

  // Unknown opcodes fall back to bypass
  function automatic jtc_dr_sel_t dr_of(input logic [IR_W-1:0] op);
    jtc_dr_sel_t r;
    case (op)
      OP_EXTEST, OP_SAMPLE: r = DR_BOUNDARY;
      OP_IDCODE: r = DR_IDENT;
      default: r = DR_BYPASS;
    endcase
    return r;
  endfunction

  always_comb begin
    nxt_st = st_ff;
    sel = dr_of(st_ff.ir);
    if (pins.tck_rise) begin
      nxt_st.tap = tap_next(st_ff.tap, pins.tms);
      case (st_ff.tap)
        CAPTURE_IR: begin
          nxt_st.ir_sh = IR_CAPTURE;
        end
        SHIFT_IR: begin
          nxt_st.ir_sh = {pins.tdi, st_ff.ir_sh[IR_W-1:1]};
        end
        CAPTURE_DR: begin
          case (sel)
            DR_BYPASS: nxt_st.bp = 1'b0;
            DR_IDENT: nxt_st.id_sh = ID_WORD;
            DR_BOUNDARY: nxt_st.bsr_sh = {CORE_OUT, pins.pad_in};
            default: nxt_st.bp = 1'b0;
          endcase
        end
        SHIFT_DR: begin
          case (sel)
            DR_BYPASS: nxt_st.bp = pins.tdi;
            DR_IDENT: nxt_st.id_sh = {pins.tdi, st_ff.id_sh[ID_W-1:1]};
            DR_BOUNDARY: nxt_st.bsr_sh = {pins.tdi, st_ff.bsr_sh[BSR_W-1:1]};
            default: nxt_st.bp = pins.tdi;
          endcase
        end
        // Pause, exit and idle states hold every shift stage
        default: nxt_st.ir_sh = st_ff.ir_sh;
      endcase
    end
    if (pins.tck_fall) begin
      case (st_ff.tap)
        UPDATE_IR: nxt_st.ir = st_ff.ir_sh;
        UPDATE_DR: begin
          if (sel == DR_BOUNDARY) begin
            nxt_st.bsr_upd = st_ff.bsr_sh;
          end
        end
        TEST_LOGIC_RESET: nxt_st.ir = OP_IDCODE;
        default: nxt_st.ir = st_ff.ir;
      endcase
      nxt_st.tdo_oe = (st_ff.tap == SHIFT_IR) || (st_ff.tap == SHIFT_DR);
      if (st_ff.tap == SHIFT_IR) begin
        nxt_st.tdo = st_ff.ir_sh[0];
      end else begin
        case (sel)
          DR_IDENT: nxt_st.tdo = st_ff.id_sh[0];
          DR_BOUNDARY: nxt_st.tdo = st_ff.bsr_sh[0];
          default: nxt_st.tdo = st_ff.bp;
        endcase
      end
    end
    if (!pins.trst_n) begin
      nxt_st.tap = TEST_LOGIC_RESET;
      nxt_st.ir = OP_IDCODE;
      nxt_st.tdo_oe = 1'b0;
    end
    // Pads follow the core except under external test or high impedance
    extest = (nxt_st.ir == OP_EXTEST);
    highz = (nxt_st.ir == OP_HIGHZ);
    nxt_st.pad_out = extest ? st_ff.bsr_upd[BSR_W-1:NPINS] : CORE_OUT;
    if (highz) begin
      nxt_st.pad_oe = '0;
    end else if (extest) begin
      nxt_st.pad_oe = '1;
    end else begin
      nxt_st.pad_oe = CORE_OE;
    end
    nxt_st.core_in = pins.pad_in;
  end

  // Core reset stands in for a power-up state; no tester reset required
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_ff <= '{tap: TEST_LOGIC_RESET, ir: OP_IDCODE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign TDO = st_ff.tdo;
  assign TDO_OE = st_ff.tdo_oe;
  assign CORE_IN = st_ff.core_in;
  assign PAD_OUT = st_ff.pad_out;
  assign PAD_OE = st_ff.pad_oe;
endmodule

// ---- jtc_tap_properties.sv ----
// Purpose: Port checks of the test access port
// Assumes: Test clock slow against core clock
// Notes: Bound to jtc_tap
`timescale 1ns/1ps
module jtc_tap_properties #(parameter int NPINS = 8) (
  // Core
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Tester
  input wire logic TCK,
  input wire logic TRST_N,
  input wire logic TDO,
  input wire logic TDO_OE,
  // Functional side and pads
  input wire logic [NPINS-1:0] CORE_OUT,
  input wire logic [NPINS-1:0] CORE_OE,
  input wire logic [NPINS-1:0] CORE_IN,
  input wire logic [NPINS-1:0] PAD_IN,
  input wire logic [NPINS-1:0] PAD_OUT,
  input wire logic [NPINS-1:0] PAD_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  oe_rise_low_a: assert property ($rose(TDO_OE) |-> !$past(TCK, 2))
    else $error("enable rose in clock high");
  tdo_on_fall_a: assert property ($changed(TDO) && TDO_OE |-> !$past(TCK, 2))
    else $error("serial out moved in clock high");
  high_quiet_a: assert property (TCK && $past(TCK, 3) |-> $stable(TDO) && $stable(TDO_OE))
    else $error("serial out moved mid high phase");
  trst_idle_a: assert property (!TRST_N [*8] |-> !TDO_OE)
    else $error("enable high in test reset");
  trst_oe_a: assert property (!TRST_N [*8] |-> PAD_OE == $past(CORE_OE))
    else $error("pad enables not functional");
  trst_out_a: assert property (!TRST_N [*8] |-> PAD_OUT == $past(CORE_OUT))
    else $error("pad values not functional");
  trst_in_a: assert property (!TRST_N [*8] |-> CORE_IN == $past(PAD_IN, 3))
    else $error("core inputs not functional");
  reset_out_a: assert property ($fell(SYS_RST) |-> !TDO_OE && PAD_OE == '0)
    else $error("outputs not cleared by reset");
  cover property ($rose(TDO_OE));
  cover property (PAD_OE == '1);
  cover property (!TRST_N [*8]);
endmodule
bind jtc_tap jtc_tap_properties #(.NPINS(NPINS)) i_props (.CORE_CLK(CORE_CLK),
  .SYS_RST(SYS_RST), .TCK(TCK), .TRST_N(TRST_N), .TDO(TDO), .TDO_OE(TDO_OE),
  .CORE_OUT(CORE_OUT), .CORE_OE(CORE_OE), .CORE_IN(CORE_IN), .PAD_IN(PAD_IN),
  .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE));

// ---- jtc_tester.sv ----
// Purpose: Behavioural boundary-scan tester
// Assumes: Test clock 125 ns, parked low between frames
// Notes: Reads serial out just before each rise
`timescale 1ns/1ps
module jtc_tester (
  // Test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  // Serial return
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic b;
  initial begin
    tck = 0;
    tms = 1;
    tdi = 0;
    trst_n = 1;
  end
  // Pins move only after a fall, so they stand long around each rise
  task automatic tick(input logic m, input logic d);
    tms = m;
    tdi = d;
    #62.5 b = tdo_oe ? tdo : 1'bx;
    tck = 1;
    #62.5 tck = 0;
  endtask
  task automatic tap_reset();
    repeat (5) tick(1, 0);
    tick(0, 0);
  endtask
  task automatic pulse_trst();
    trst_n = 0;
    #100.5 trst_n = 1;
    #100.5;
  endtask
  // From idle: scan n bits, least significant first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    dout = '0;
    tick(1, 0);
    if (ir) tick(1, 0);
    tick(0, 0);
    tick(0, 0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = b;
    end
    tick(1, 0);
    tick(0, 0);
  endtask
endmodule

// ---- test_jtc_tap.sv ----
// Purpose: Self-checking bench of the test access port
// Assumes: Tester model owns the test pins
// Notes: Rows cover every defined opcode and one unknown opcode, resets after
`timescale 1ns/1ps
module test_jtc_tap;
  import jtc_pkg::*;
  localparam logic [31:0] DIN = 32'hC3A5_0F1E;
  localparam logic [31:0] ID = {4'h1, 16'h1234, 11'h055, 1'b1};
  localparam logic [31:0] BND = {DIN[15:0], 8'hA5, 8'h96};
  localparam logic [31:0] BYP = {DIN[30:0], 1'b0};
  logic clk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [7:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
  logic [31:0] got;
  int n_mismatch, samples_checked, cycles;
  // Opcode, pad enables, pad values, data scanned out
  logic [51:0] rows [6] = '{{OP_SAMPLE, 8'h3C, 8'hA5, BND}, {OP_EXTEST, 8'hFF, 8'hC3, BND},
    {OP_IDCODE, 8'h3C, 8'hA5, ID}, {OP_HIGHZ, 8'h00, 8'hA5, BYP},
    {OP_BYPASS, 8'h3C, 8'hA5, BYP}, {4'h7, 8'h3C, 8'hA5, BYP}};
  jtc_tap i_dut (.CORE_CLK(clk), .SYS_RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi),
    .TRST_N(trst_n), .TDO(tdo), .TDO_OE(tdo_oe), .CORE_OUT(core_out), .CORE_OE(core_oe),
    .CORE_IN(core_in), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe));
  jtc_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Full run needs some 6000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1;
    core_out = 8'hA5;
    core_oe = 8'h3C;
    pad_in = 8'h96;
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (5) @(posedge clk);
    i_tester.tap_reset();
    foreach (rows[k]) begin
      i_tester.scan(1, 4, 32'(rows[k][51:48]), got);
      check("ir capture", 32'h1, got);
      check("pad enables", 32'(rows[k][47:40]), 32'(pad_oe));
      i_tester.scan(0, 32, DIN, got);
      check("data out", rows[k][31:0], got);
      check("pad values", 32'(rows[k][39:32]), 32'(pad_out));
    end
    // Abandon a data scan midway with five high clocks
    i_tester.scan(1, 4, 32'(OP_BYPASS), got);
    i_tester.tick(1, 0);
    i_tester.tick(0, 0);
    i_tester.tick(0, 0);
    i_tester.tap_reset();
    check("idle enable", 32'h0, 32'(tdo_oe));
    i_tester.scan(0, 32, DIN, got);
    check("id after reset", ID, got);
    i_tester.scan(1, 4, 32'(OP_EXTEST), got);
    @(posedge clk);
    pad_in <= 8'h69;
    i_tester.pulse_trst();
    check("pads after test reset", 32'h3C, 32'(pad_oe));
    check("pad values after test reset", 32'hA5, 32'(pad_out));
    check("core inputs", 32'h69, 32'(core_in));
    // Test reset leaves the port in its reset state; scans start from idle
    i_tester.tick(0, 0);
    i_tester.scan(0, 32, DIN, got);
    check("id after test reset", ID, got);
    tally_and_finish();
  end
endmodule
